// ---- capture_and_interval_timer.sv ----
/*
 * Capture and interval timer with an AHB-Lite register slave.
 * Assumes a single AHB-Lite master, word transfers and synchronous capture inputs.
 */
// Implementation choice: register access over AHB-Lite.
`timescale 1ns/10ps
`include "timer_regs.svh"

module capture_and_interval_timer
    import timer_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic capture_input_zero,
    input wire logic capture_input_one,
    output logic capture_irq,
    output logic interval_irq
);

    // ------------------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------------------
    bus_phase_t phase_ff, nxt_phase;
    byte_t addr_ff, nxt_addr;
    logic [31:0] hrdata_ff, nxt_hrdata;
    logic accept, wr_en, rd_now, addr_ok;

    // Reads take one wait state so that a write just before is already visible.
    assign accept = hsel && htrans[1] && hready;
    assign addr_ok = (haddr[31:10] == 22'h000000) && (haddr[1:0] == 2'h0);
    assign wr_en = (phase_ff == PH_WRITE);
    assign rd_now = (phase_ff == PH_RD_WAIT);
    assign hreadyout = (phase_ff != PH_RD_WAIT);
    assign hresp = 1'b0;
    assign hrdata = hrdata_ff;

    always_comb begin
        nxt_phase = PH_IDLE;
        nxt_addr = addr_ff;
        case (phase_ff)
            PH_RD_WAIT: begin
                nxt_phase = PH_RD_DONE;
            end
            PH_IDLE, PH_RD_DONE, PH_WRITE: begin
                if (accept) begin
                    nxt_phase = hwrite ? PH_WRITE : PH_RD_WAIT;
                    nxt_addr = addr_ok ? haddr[9:2] : 8'h00;
                end
            end
            default: begin
                nxt_phase = PH_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            phase_ff <= PH_IDLE;
            addr_ff <= 8'h00;
        end else begin
            phase_ff <= nxt_phase;
            addr_ff <= nxt_addr;
        end
    end

    // ------------------------------------------------------------------------
    // Timer tick
    // ------------------------------------------------------------------------
    logic [`TICK_CNT_W-1:0] tick_cnt_ff, nxt_tick_cnt;
    logic tick;

    // own tick rate
    // The timer domain is a divided enable, so bus accesses need no crossing.
    assign tick = (tick_cnt_ff == `TICK_CNT_W'(`TICK_CYCLES - 1));
    always_comb begin
        nxt_tick_cnt = tick ? `TICK_CNT_W'(0) : tick_cnt_ff + `TICK_CNT_W'(1);
    end

    // ------------------------------------------------------------------------
    // Free-running timer
    // ------------------------------------------------------------------------
    logic [15:0] timer_ff, nxt_timer;
    byte_t hold_hi_ff, nxt_hold_hi, wr_lo_ff, nxt_wr_lo;

    always_comb begin
        nxt_timer = timer_ff;
        nxt_hold_hi = hold_hi_ff;
        nxt_wr_lo = wr_lo_ff;
        if (tick) begin
            nxt_timer = timer_ff + 16'h0001;
        end
        if (wr_en && addr_ff == `IDX_FREE_LOW) begin
            nxt_wr_lo = hwdata[7:0];
        end
        if (wr_en && addr_ff == `IDX_FREE_HIGH) begin
            nxt_timer = {hwdata[7:0], wr_lo_ff};
        end
        if (rd_now && addr_ff == `IDX_FREE_LOW) begin
            nxt_hold_hi = timer_ff[15:8];
        end
    end

    // ------------------------------------------------------------------------
    // Capture
    // ------------------------------------------------------------------------
    byte_t cap_ff [4];
    byte_t nxt_cap [4];
    logic [3:0] lock_ff, nxt_lock, ev, flags_ff, nxt_flags, inte_ff, nxt_inte;
    logic [1:0] cap_prev_ff, nxt_cap_prev;
    byte_t cfg_ff, nxt_cfg, slice;
    logic rise0, fall0, rise1, fall1, wide, first_hold;

    assign rise0 = capture_input_zero && !cap_prev_ff[0];
    assign fall0 = !capture_input_zero && cap_prev_ff[0];
    assign rise1 = capture_input_one && !cap_prev_ff[1];
    assign fall1 = !capture_input_one && cap_prev_ff[1];
    assign wide = cfg_ff[`CFG_WIDE];
    assign first_hold = cfg_ff[`CFG_FIRST_HOLD];
    assign slice = 8'(timer_ff >> cfg_ff[`CFG_PRESCALE_HI:`CFG_PRESCALE_LO]);

    always_comb begin
        nxt_cap = cap_ff;
        nxt_lock = lock_ff;
        nxt_cap_prev = {capture_input_one, capture_input_zero};
        ev[0] = rise0;
        ev[1] = wide ? rise0 : rise1;
        ev[2] = fall0;
        ev[3] = wide ? fall0 : fall1;
        for (int k = 0; k < 4; k++) begin
            if (wr_en && addr_ff == 8'(`IDX_CAP_ZERO_RISE + k)) begin
                nxt_cap[k] = hwdata[7:0];
            end
            if (rd_now && addr_ff == 8'(`IDX_CAP_ZERO_RISE + k)) begin
                nxt_lock[k] = 1'b0;
            end
        end
        for (int k = 0; k < 4; k++) begin
            if (ev[k] && !lock_ff[wide ? (k & 2) : k]) begin
                if (!wide) begin
                    nxt_cap[k] = slice;
                end else begin
                    nxt_cap[k] = (k % 2 == 1) ? timer_ff[15:8] : timer_ff[7:0];
                end
                if (first_hold) begin
                    nxt_lock[k] = 1'b1;
                end
            end
        end
    end

    always_comb begin
        nxt_flags = flags_ff;
        nxt_inte = inte_ff;
        nxt_cfg = cfg_ff;
        if (wr_en && addr_ff == `IDX_CAP_FLAGS) begin
            nxt_flags = flags_ff & ~hwdata[3:0];
        end
        if (wr_en && addr_ff == `IDX_CAP_IRQ_EN) begin
            nxt_inte = hwdata[3:0];
        end
        if (wr_en && addr_ff == `IDX_TIMER_CONFIG) begin
            nxt_cfg = hwdata[7:0] & `CFG_WMASK;
        end
        nxt_flags[`FLAG_ZERO_RISE] = nxt_flags[`FLAG_ZERO_RISE] | rise0;
        nxt_flags[`FLAG_ZERO_FALL] = nxt_flags[`FLAG_ZERO_FALL] | fall0;
        nxt_flags[`FLAG_ONE_RISE] = nxt_flags[`FLAG_ONE_RISE] | (rise1 && !wide);
        nxt_flags[`FLAG_ONE_FALL] = nxt_flags[`FLAG_ONE_FALL] | (fall1 && !wide);
    end

    // ------------------------------------------------------------------------
    // Interval timer
    // ------------------------------------------------------------------------
    logic [11:0] pit_ff, nxt_pit, reload_ff, nxt_reload;
    logic [3:0] pit_hold_ff, nxt_pit_hold;
    logic nxt_interval_irq, interval_irq_ff, capture_irq_ff;

    always_comb begin
        nxt_pit = pit_ff;
        nxt_pit_hold = pit_hold_ff;
        nxt_reload = reload_ff;
        nxt_interval_irq = 1'b0;
        if (tick) begin
            if (pit_ff == 12'h000) begin
                nxt_pit = reload_ff;
                nxt_interval_irq = 1'b1;
            end else begin
                nxt_pit = pit_ff - 12'h001;
            end
        end
        if (wr_en && addr_ff == `IDX_RELOAD_LOW) begin
            nxt_reload[7:0] = hwdata[7:0];
        end
        if (wr_en && addr_ff == `IDX_RELOAD_HIGH) begin
            nxt_reload[11:8] = hwdata[3:0];
        end
        if (rd_now && addr_ff == `IDX_PIT_LOW) begin
            nxt_pit_hold = pit_ff[11:8];
        end
    end

    // ------------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------------
    always_comb begin
        nxt_hrdata = hrdata_ff;
        if (rd_now) begin
            case (addr_ff)
                `IDX_FREE_LOW: nxt_hrdata = {24'h000000, timer_ff[7:0]};
                `IDX_FREE_HIGH: nxt_hrdata = {24'h000000, hold_hi_ff};
                `IDX_CAP_ZERO_RISE: nxt_hrdata = {24'h000000, cap_ff[0]};
                `IDX_CAP_ONE_RISE: nxt_hrdata = {24'h000000, cap_ff[1]};
                `IDX_CAP_ZERO_FALL: nxt_hrdata = {24'h000000, cap_ff[2]};
                `IDX_CAP_ONE_FALL: nxt_hrdata = {24'h000000, cap_ff[3]};
                `IDX_PIT_LOW: nxt_hrdata = {24'h000000, pit_ff[7:0]};
                `IDX_PIT_HIGH: nxt_hrdata = {28'h0000000, pit_hold_ff};
                `IDX_RELOAD_LOW: nxt_hrdata = {24'h000000, reload_ff[7:0]};
                `IDX_RELOAD_HIGH: nxt_hrdata = {28'h0000000, reload_ff[11:8]};
                `IDX_TIMER_CONFIG: nxt_hrdata = {24'h000000, cfg_ff};
                `IDX_CAP_IRQ_EN: nxt_hrdata = {28'h0000000, inte_ff};
                `IDX_CAP_FLAGS: nxt_hrdata = {28'h0000000, flags_ff};
                default: nxt_hrdata = 32'h00000000;
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------------------
    // all reset to zero
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tick_cnt_ff <= `TICK_CNT_W'(0);
            timer_ff <= 16'h0000;
            hold_hi_ff <= `REG_RESET;
            wr_lo_ff <= `REG_RESET;
            for (int k = 0; k < 4; k++) begin
                cap_ff[k] <= `REG_RESET;
            end
            lock_ff <= 4'h0;
            cap_prev_ff <= 2'h0;
            flags_ff <= 4'h0;
            inte_ff <= 4'h0;
            cfg_ff <= `REG_RESET;
            pit_ff <= 12'h000;
            pit_hold_ff <= 4'h0;
            reload_ff <= 12'h000;
            interval_irq_ff <= 1'b0;
            capture_irq_ff <= 1'b0;
            hrdata_ff <= 32'h00000000;
        end else begin
            tick_cnt_ff <= nxt_tick_cnt;
            timer_ff <= nxt_timer;
            hold_hi_ff <= nxt_hold_hi;
            wr_lo_ff <= nxt_wr_lo;
            cap_ff <= nxt_cap;
            lock_ff <= nxt_lock;
            cap_prev_ff <= nxt_cap_prev;
            flags_ff <= nxt_flags;
            inte_ff <= nxt_inte;
            cfg_ff <= nxt_cfg;
            pit_ff <= nxt_pit;
            pit_hold_ff <= nxt_pit_hold;
            reload_ff <= nxt_reload;
            interval_irq_ff <= nxt_interval_irq;
            capture_irq_ff <= |(nxt_flags & nxt_inte);
            hrdata_ff <= nxt_hrdata;
        end
    end

    assign capture_irq = capture_irq_ff;
    assign interval_irq = interval_irq_ff;

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    AST_FREE_SNAPSHOT: assert property (
        rd_now && addr_ff == `IDX_FREE_LOW |=> hold_hi_ff == $past(timer_ff[15:8]))
        else $error("High byte not snapshotted on low read.");
    AST_FREE_SAMPLE: assert property (
        rd_now && addr_ff == `IDX_FREE_LOW |=> hrdata_ff[7:0] == $past(timer_ff[7:0]) && hreadyout)
        else $error("Low byte read did not return the sampled timer.");
    AST_FREE_WRITE: assert property (
        wr_en && addr_ff == `IDX_FREE_HIGH |=> timer_ff == {$past(hwdata[7:0]), $past(wr_lo_ff)})
        else $error("Timer not loaded from high write and held low byte.");
    AST_CAP_SLICE: assert property (
        rise0 && !wide && !lock_ff[0] |=> cap_ff[0] == $past(slice))
        else $error("Capture zero rise did not store the prescaled slice.");
    AST_CAP_ONE_FALL: assert property (
        fall1 && !wide && !lock_ff[3] |=> cap_ff[3] == $past(slice) && flags_ff[`FLAG_ONE_FALL])
        else $error("Capture one fall not stored or flagged.");
    AST_WIDE_RISE: assert property (
        rise0 && wide && !lock_ff[0]
        |=> cap_ff[1] == $past(timer_ff[15:8]) && cap_ff[0] == $past(timer_ff[7:0]))
        else $error("Wide rise did not split timer across both registers.");
    AST_WIDE_NO_ONE: assert property (
        wide && !wr_en |=> $stable(flags_ff[`FLAG_ONE_RISE]))
        else $error("Capture one flagged while wide mode set.");
    AST_FIRST_HOLD: assert property (
        lock_ff[2] && !wide && !wr_en && !rd_now |=> $stable(cap_ff[2]))
        else $error("Held capture changed before being read.");
    AST_PIT_HIGH: assert property (
        rd_now && addr_ff == `IDX_PIT_HIGH
        |=> hrdata_ff[7:4] == 4'h0 && hrdata_ff[3:0] == $past(pit_hold_ff))
        else $error("Interval high read wrong.");
    AST_PIT_RELOAD: assert property (
        tick && pit_ff == 12'h000 |=> pit_ff == $past(reload_ff) && interval_irq)
        else $error("Interval expiry did not reload and signal.");
    AST_TIMER_INC: assert property (
        tick && !(wr_en && addr_ff == `IDX_FREE_HIGH) |=> timer_ff == $past(timer_ff) + 16'h0001)
        else $error("Timer did not advance on tick.");
    AST_TICK_GAP: assert property (
        tick |=> !tick [*8])
        else $error("Timer ticks too close together.");

    COV_WIDE: cover property (rise0 && wide ##1 fall0 && wide);
    COV_HOLD: cover property (lock_ff[0] && rise0);
    COV_PIT: cover property (interval_irq);
    COV_COHERENT: cover property (rd_now && addr_ff == `IDX_FREE_LOW ##[2:20]
        rd_now && addr_ff == `IDX_FREE_HIGH);

endmodule

// ---- timer_regs.svh ----
/*
 * Register indices, field positions, reset values and timing counts for the
 * capture and interval timer.
 * Assumes a 250 MHz system clock; each register index sits at byte address 4*index.
 */
`ifndef TIMER_REGS_SVH
`define TIMER_REGS_SVH

// ----------------------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------------------
`define IDX_FREE_LOW 8'h20
`define IDX_FREE_HIGH 8'h21
`define IDX_CAP_ZERO_RISE 8'h22
`define IDX_CAP_ONE_RISE 8'h23
`define IDX_CAP_ZERO_FALL 8'h24
`define IDX_CAP_ONE_FALL 8'h25
`define IDX_PIT_LOW 8'h26
`define IDX_PIT_HIGH 8'h27
`define IDX_RELOAD_LOW 8'h28
`define IDX_RELOAD_HIGH 8'h29
`define IDX_TIMER_CONFIG 8'h2A
`define IDX_CAP_IRQ_EN 8'h2B
`define IDX_CAP_FLAGS 8'h2C

// ----------------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------------
`define CFG_FIRST_HOLD 7
`define CFG_PRESCALE_HI 6
`define CFG_PRESCALE_LO 4
`define CFG_WIDE 3
`define CFG_WMASK 8'hF8
`define FLAG_ZERO_RISE 0
`define FLAG_ZERO_FALL 1
`define FLAG_ONE_RISE 2
`define FLAG_ONE_FALL 3
`define REG_RESET 8'h00

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CLK_PERIOD_NS 4
`define TICK_PERIOD_NS 1000
`define TICK_CYCLES (`TICK_PERIOD_NS / `CLK_PERIOD_NS)
`define TICK_CNT_W 8

`endif

// ---- timer_pkg.sv ----
/*
 * Types shared by the capture and interval timer.
 * Assumes timer_regs.svh supplies every register index and field position.
 */
package timer_pkg;

    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_RD_WAIT = 2'b01,
        PH_RD_DONE = 2'b11,
        PH_WRITE = 2'b10
    } bus_phase_t;

    typedef logic [7:0] byte_t;

endpackage

// ---- capture_source.sv ----
/*
 * Model of the two external edge sources that feed the capture inputs.
 * Assumes the timer samples both inputs on the rising edge of clk.
 */
`timescale 1ns/10ps

module capture_source (
    input wire logic clk,
    output logic cap_zero,
    output logic cap_one
);
    // ------------------------------------------------------------------------
    // Line levels
    // ------------------------------------------------------------------------
    initial begin
        cap_zero = 1'b0;
        cap_one = 1'b0;
    end

    // Waits dly extra cycles first, so both prompt and slow sources occur.
    // Levels move just after an edge, so the timer never sees a half-set line.
    task automatic drive(input logic [1:0] mask, input logic lvl, input int dly);
        repeat (dly + 1) @(posedge clk);
        if (mask[0]) begin
            cap_zero <= lvl;
        end
        if (mask[1]) begin
            cap_one <= lvl;
        end
    endtask
endmodule

// ---- capture_and_interval_timer_tb_top.sv ----
/*
 * Self-checking bench for the capture and interval timer.
 * Assumes the design body, timer_regs.svh, and capture_source on the pins.
 */
`timescale 1ns/10ps
`include "timer_regs.svh"

module capture_and_interval_timer_tb_top
    import timer_pkg::*;
;
    logic clk, rst, hsel, hwrite, hreadyout, hresp, capture_irq, interval_irq;
    logic cap_zero, cap_one;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata;
    int n_errors, total_checks, cycles, seed, n;
    byte_t d, d2;
    logic [15:0] v;

    capture_and_interval_timer capture_and_interval_timer_i (
        .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .capture_input_zero(cap_zero), .capture_input_one(cap_one),
        .capture_irq(capture_irq), .interval_irq(interval_irq)
    );

    capture_source capture_source_i (.clk(clk), .cap_zero(cap_zero), .cap_one(cap_one));

    // ------------------------------------------------------------------------
    // Bus master and comparisons
    // ------------------------------------------------------------------------
    // Starts after a rising edge; each phase is held until ready is seen high at a
    // rising edge, so a slow answer never cuts a transfer short.
    task automatic bus(input logic wr, input byte_t idx, input byte_t wd, output byte_t rd);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {22'h000000, idx, 2'b00};
        hwrite <= wr;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {24'h000000, wd};
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata[7:0];
    endtask

    task automatic wr(input byte_t idx, input byte_t wd);
        byte_t x;
        bus(1'b1, idx, wd, x);
    endtask

    task automatic rd(input byte_t idx, output byte_t r);
        bus(1'b0, idx, 8'h00, r);
    endtask

    task automatic set_timer(input logic [15:0] t);
        wr(`IDX_FREE_LOW, t[7:0]);
        wr(`IDX_FREE_HIGH, t[15:8]);
    endtask

    task automatic wait_pit(output int k);
        k = 0;
        do begin
            @(negedge clk);
            k++;
        end while (interval_irq !== 1'b1 && k < 2000);
    endtask

    function automatic byte_t slice(input logic [15:0] t, input int p);
        return 8'(t >> p);
    endfunction

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // A tick may land between setting the timer and the event, so one step is allowed.
    task automatic chk_near(input logic [15:0] got, input logic [15:0] a, input logic [15:0] b);
        total_checks++;
        if (got !== a && got !== b) begin
            n_errors++;
            $display("Error t=%0t got=%h exp=%h or %h", $time, got, a, b);
        end
    endtask

    task automatic print_verdict;
        if (n_errors == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------------
    // Clock, timeout and main sequence
    // ------------------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 12000) begin
            n_errors++;
            print_verdict();
        end
    end

    initial begin
        seed = 32'h93E6;
        rst = 1'b1;
        hsel = 1'b0;
        htrans = 2'b00;
        haddr = 32'h00000000;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h00000000;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        for (int i = 8'h20; i <= 8'h2C; i++) begin
            rd(8'(i), d);
            chk(16'(d), 16'h0000);
        end
        wr(8'h40, 8'hA5);
        rd(8'h40, d);
        chk(16'(d), 16'h0000);
        chk(16'(hresp), 16'h0000);
        set_timer(16'h12FF);
        wr(`IDX_FREE_LOW, 8'h55);
        rd(`IDX_FREE_LOW, d);
        repeat (300) @(posedge clk);
        rd(`IDX_FREE_HIGH, d2);
        chk_near({d2, d}, 16'h12FF, 16'h1300);
        wr(`IDX_FREE_HIGH, 8'h34);
        rd(`IDX_FREE_LOW, d);
        rd(`IDX_FREE_HIGH, d2);
        chk_near({d2, d}, 16'h3455, 16'h3456);
        set_timer(16'hFFFF);
        repeat (260) @(posedge clk);
        rd(`IDX_FREE_LOW, d);
        rd(`IDX_FREE_HIGH, d2);
        chk_near({d2, d}, 16'h0000, 16'h0001);
        for (int p = 0; p < 8; p++) begin
            v = 16'($random(seed));
            wr(`IDX_TIMER_CONFIG, 8'(p << 4));
            set_timer(v);
            capture_source_i.drive(2'b11, 1'b1, p % 3);
            capture_source_i.drive(2'b11, 1'b0, 0);
            repeat (2) @(posedge clk);
            for (int r = 0; r < 4; r++) begin
                rd(8'(`IDX_CAP_ZERO_RISE + r), d);
                chk_near(16'(d), 16'(slice(v, p)), 16'(slice(v + 16'h0001, p)));
            end
        end
        rd(`IDX_CAP_FLAGS, d);
        chk(16'(d), 16'h000F);
        chk(16'(capture_irq), 16'h0000);
        wr(`IDX_CAP_IRQ_EN, 8'h04);
        repeat (2) @(negedge clk);
        chk(16'(capture_irq), 16'h0001);
        wr(`IDX_CAP_FLAGS, 8'h0F);
        repeat (2) @(negedge clk);
        chk(16'(capture_irq), 16'h0000);
        wr(`IDX_TIMER_CONFIG, 8'h08);
        v = 16'($random(seed));
        set_timer(v);
        capture_source_i.drive(2'b01, 1'b1, 1);
        capture_source_i.drive(2'b10, 1'b1, 0);
        capture_source_i.drive(2'b01, 1'b0, 0);
        repeat (2) @(posedge clk);
        rd(`IDX_CAP_ZERO_RISE, d);
        rd(`IDX_CAP_ONE_RISE, d2);
        chk_near({d2, d}, v, v + 16'h0001);
        rd(`IDX_CAP_ZERO_FALL, d);
        rd(`IDX_CAP_ONE_FALL, d2);
        chk_near({d2, d}, v, v + 16'h0001);
        rd(`IDX_CAP_FLAGS, d);
        chk(16'(d), 16'h0003);
        wr(`IDX_TIMER_CONFIG, 8'h80);
        set_timer(16'h0011);
        capture_source_i.drive(2'b01, 1'b1, 0);
        capture_source_i.drive(2'b01, 1'b0, 0);
        set_timer(16'h0077);
        capture_source_i.drive(2'b01, 1'b1, 0);
        repeat (2) @(posedge clk);
        rd(`IDX_CAP_ZERO_RISE, d);
        chk_near(16'(d), 16'h0011, 16'h0012);
        capture_source_i.drive(2'b01, 1'b0, 0);
        capture_source_i.drive(2'b01, 1'b1, 0);
        repeat (2) @(posedge clk);
        rd(`IDX_CAP_ZERO_RISE, d);
        chk_near(16'(d), 16'h0077, 16'h0078);
        wr(`IDX_RELOAD_LOW, 8'h02);
        wr(`IDX_RELOAD_HIGH, 8'h00);
        wait_pit(n);
        wait_pit(n);
        wait_pit(n);
        chk(16'(n), 16'h02EE);
        wr(`IDX_RELOAD_LOW, 8'h00);
        wr(`IDX_RELOAD_HIGH, 8'h01);
        wait_pit(n);
        rd(`IDX_PIT_LOW, d);
        repeat (300) @(posedge clk);
        rd(`IDX_PIT_HIGH, d2);
        chk(16'(d), 16'h0000);
        chk(16'(d2), 16'h0001);
        print_verdict();
    end
endmodule
